// File: timer_pair_params.svh
`ifndef TIMER_PAIR_PARAMS_SVH
`define TIMER_PAIR_PARAMS_SVH
// Function
// - Second timer counts while its run bit is set; halted, both count bytes hold.
// - First timer counts while its run bit is set; halted, both count bytes hold, save the mode 3 high byte, which runs on the second run bit.
// - External interrupt zero is level-sensitive when its type bit is 0, edge when 1.
// - Edge mode: a falling edge sets the zero detect flag until software or service clears.
// - Level mode: the zero detect flag follows the inverted pin, never latched.
// - Second timer gate set: counts only while run is set and pin one is high.
// - Second timer source bit picks internal ticks or falling edges on its count pin.
// - Mode bits: 00 prescaled 13-bit, 01 16-bit, 10 8-bit reload, 11 special.
// - Mode 2 reloads the low count byte from the high byte on every overflow.
// - Second timer in mode 3 holds its count whatever its run bit says.
// - First timer gate set: counts, save the mode 3 high byte, only while run is set and pin zero is high.
// - First timer in mode 3 splits into two independent 8-bit counters.
// - Internal count clock is the input clock divided by 12 or 4 per select bit.
`define IDX_CTL_FLAGS 8'h88
`define IDX_MODE_CFG 8'h89
`define IDX_CNT_A_LOW 8'h8A
`define IDX_CNT_B_LOW 8'h8B
`define IDX_CNT_A_HIGH 8'h8C
`define IDX_CNT_B_HIGH 8'h8D
`define IDX_CLKDIV_SEL 8'h8E
`define ADDR_IRQ_STATUS 10'h300
`define ADDR_IRQ_CLEAR 10'h304
`define ADDR_IRQ_ENABLE 10'h308
`define OVF_FLAG_B 7
`define RUN_CTL_B 6
`define OVF_FLAG_A 5
`define RUN_CTL_A 4
`define XIRQ_B_DETECT 3
`define XIRQ_B_TYPE 2
`define XIRQ_A_DETECT 1
`define XIRQ_A_TYPE 0
`define GATE_B 7
`define SRC_B 6
`define MODE_B_HI 5
`define MODE_B_LO 4
`define GATE_A 3
`define SRC_A 2
`define MODE_A_HI 1
`define MODE_A_LO 0
`define CLKDIV_SEL_B 4
`define CLKDIV_SEL_A 3
`define CTL_RESET 8'h00
`define MODE_RESET 8'h00
`define DIV_SLOW 4'd12
`define DIV_FAST_MASK 4'h3
`define CNT_FULL 8'hFF
`define IRQ_OVF_A 0
`define IRQ_OVF_B 1
`define IRQ_DET_A 2
`define IRQ_DET_B 3
`endif

// File: timer_pair_pkg.sv
package timer_pair_pkg;
    typedef enum logic [1:0] {MODE_PRESCALE, MODE_SIXTEEN, MODE_RELOAD, MODE_SPECIAL} mode_e;
    typedef struct packed {
        logic xirqBPin;
        logic xirqAPin;
        logic countPinB;
        logic countPinA;
    } pins_s;
    typedef struct packed {
        logic xirqB;
        logic xirqA;
        logic ovfB;
        logic ovfA;
    } svc_s;
endpackage : timer_pair_pkg

// File: timer_pair_ctl.sv
`include "timer_pair_params.svh"
module timer_pair_ctl (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire timer_pair_pkg::pins_s pins,
    input wire timer_pair_pkg::svc_s svcStart,
    output logic [7:0] ctlFlags,
    output logic irq
);
    import timer_pair_pkg::*;

    // Returns {overflow, high, low} after one count step in the given mode.
    function automatic logic [16:0] stepCount(input mode_e m, input logic [7:0] hi, input logic [7:0] lo);
        logic [5:0] low5;
        logic [8:0] hi9;
        logic [16:0] full;
        low5 = {1'b0, lo[4:0]} + 6'd1;
        hi9 = {1'b0, hi} + 9'd1;
        full = {1'b0, hi, lo} + 17'd1;
        case (m)
            MODE_PRESCALE: begin
                if (low5[5]) begin
                    stepCount = {hi9[8], hi9[7:0], lo[7:5], low5[4:0]};
                end else begin
                    stepCount = {1'b0, hi, lo[7:5], low5[4:0]};
                end
            end
            MODE_SIXTEEN: stepCount = full;
            MODE_RELOAD: begin
                if (lo == `CNT_FULL) begin
                    stepCount = {1'b1, hi, hi};
                end else begin
                    stepCount = {1'b0, hi, lo + 8'd1};
                end
            end
            default: stepCount = {1'b0, hi, lo};
        endcase
    endfunction : stepCount

    logic [7:0] tmrCtlFlags;
    logic [7:0] tmrModeCfg;
    logic [7:0] clkdivSel;
    logic [7:0] cntALow, cntAHigh, cntBLow, cntBHigh;
    logic [3:0] irqStatus, irqEnable;
    logic [3:0] sync1, sync2, sync3, pinLevel, pinPrev;
    logic [3:0] preCnt;
    logic wrPend;
    logic [9:0] wrAddr;
    logic [7:0] next_ctl;
    logic [3:0] irqEvent;
    mode_e modeA, modeB;
    logic tickSlow, tickFast, tickA, tickB;
    logic fallCntA, fallCntB, fallXA, fallXB;
    logic stepA, stepB, stepSplitHigh;
    logic [16:0] nextA, nextB;
    logic [8:0] splitHigh;
    logic wrCtl, wrCntAL, wrCntAH, wrCntBL, wrCntBH;
    logic [31:0] rdVal;

    assign modeA = mode_e'(tmrModeCfg[`MODE_A_HI:`MODE_A_LO]);
    assign modeB = mode_e'(tmrModeCfg[`MODE_B_HI:`MODE_B_LO]);
    assign ctlFlags = tmrCtlFlags;

    // A pin change is taken once the second and third stages agree.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
            pinLevel <= 4'h0;
            pinPrev <= 4'h0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            pinLevel <= (sync2 & sync3) | (pinLevel & (sync2 ^ sync3));
            pinPrev <= pinLevel;
        end
    end
    assign fallCntA = pinPrev[0] & ~pinLevel[0];
    assign fallCntB = pinPrev[1] & ~pinLevel[1];
    assign fallXA = pinPrev[2] & ~pinLevel[2];
    assign fallXB = pinPrev[3] & ~pinLevel[3];

    // One shared divider serves both rates, so the two timers stay phase aligned.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preCnt <= 4'h0;
        end else if (preCnt == `DIV_SLOW - 4'd1) begin
            preCnt <= 4'h0;
        end else begin
            preCnt <= preCnt + 4'd1;
        end
    end
    assign tickSlow = preCnt == 4'h0;
    assign tickFast = (preCnt & `DIV_FAST_MASK) == 4'h0;
    assign tickA = clkdivSel[`CLKDIV_SEL_A] ? tickFast : tickSlow;
    assign tickB = clkdivSel[`CLKDIV_SEL_B] ? tickFast : tickSlow;

    assign stepA = tmrCtlFlags[`RUN_CTL_A] & (~tmrModeCfg[`GATE_A] | pinLevel[2])
        & (tmrModeCfg[`SRC_A] ? fallCntA : tickA);
    assign stepB = tmrCtlFlags[`RUN_CTL_B] & (~tmrModeCfg[`GATE_B] | pinLevel[3])
        & (tmrModeCfg[`SRC_B] ? fallCntB : tickB);
    assign nextA = stepCount(modeA, cntAHigh, cntALow);
    assign nextB = stepCount(modeB, cntBHigh, cntBLow);
    // The split high half borrows the second timer's run bit, as legacy code expects.
    assign stepSplitHigh = (modeA == MODE_SPECIAL) & tmrCtlFlags[`RUN_CTL_B] & tickA;
    assign splitHigh = {1'b0, cntAHigh} + 9'd1;

    assign wrCtl = wrPend && wrAddr == {`IDX_CTL_FLAGS, 2'b00};
    assign wrCntAL = wrPend && wrAddr == {`IDX_CNT_A_LOW, 2'b00};
    assign wrCntAH = wrPend && wrAddr == {`IDX_CNT_A_HIGH, 2'b00};
    assign wrCntBL = wrPend && wrAddr == {`IDX_CNT_B_LOW, 2'b00};
    assign wrCntBH = wrPend && wrAddr == {`IDX_CNT_B_HIGH, 2'b00};

    // Software writes first, service clears next, hardware sets last so a set wins.
    always_comb begin
        next_ctl = tmrCtlFlags;
        if (wrCtl) begin
            next_ctl = hwdata[7:0];
        end
        if (svcStart.ovfA) next_ctl[`OVF_FLAG_A] = 1'b0;
        if (svcStart.ovfB) next_ctl[`OVF_FLAG_B] = 1'b0;
        if (tmrCtlFlags[`XIRQ_A_TYPE]) begin
            if (svcStart.xirqA) next_ctl[`XIRQ_A_DETECT] = 1'b0;
            if (fallXA) next_ctl[`XIRQ_A_DETECT] = 1'b1;
        end else begin
            next_ctl[`XIRQ_A_DETECT] = ~pinLevel[2];
        end
        if (tmrCtlFlags[`XIRQ_B_TYPE]) begin
            if (svcStart.xirqB) next_ctl[`XIRQ_B_DETECT] = 1'b0;
            if (fallXB) next_ctl[`XIRQ_B_DETECT] = 1'b1;
        end else begin
            next_ctl[`XIRQ_B_DETECT] = ~pinLevel[3];
        end
        if (stepA && nextA[16] && modeA != MODE_SPECIAL) next_ctl[`OVF_FLAG_A] = 1'b1;
        if (stepA && modeA == MODE_SPECIAL && cntALow == `CNT_FULL) next_ctl[`OVF_FLAG_A] = 1'b1;
        if (stepB && nextB[16] && modeA != MODE_SPECIAL) next_ctl[`OVF_FLAG_B] = 1'b1;
        if (stepSplitHigh && splitHigh[8]) next_ctl[`OVF_FLAG_B] = 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmrCtlFlags <= `CTL_RESET;
        end else begin
            tmrCtlFlags <= next_ctl;
        end
    end

    // A register write in the data phase takes priority over a count step.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cntALow <= 8'h00;
            cntAHigh <= 8'h00;
        end else begin
            if (wrCntAL) begin
                cntALow <= hwdata[7:0];
            end else if (stepA && modeA == MODE_SPECIAL) begin
                cntALow <= cntALow + 8'd1;
            end else if (stepA) begin
                cntALow <= nextA[7:0];
            end
            if (wrCntAH) begin
                cntAHigh <= hwdata[7:0];
            end else if (stepSplitHigh) begin
                cntAHigh <= splitHigh[7:0];
            end else if (stepA && modeA != MODE_SPECIAL) begin
                cntAHigh <= nextA[15:8];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cntBLow <= 8'h00;
            cntBHigh <= 8'h00;
        end else begin
            if (wrCntBL) begin
                cntBLow <= hwdata[7:0];
            end else if (stepB) begin
                cntBLow <= nextB[7:0];
            end
            if (wrCntBH) begin
                cntBHigh <= hwdata[7:0];
            end else if (stepB) begin
                cntBHigh <= nextB[15:8];
            end
        end
    end

    assign irqEvent[`IRQ_OVF_A] = next_ctl[`OVF_FLAG_A] & ~tmrCtlFlags[`OVF_FLAG_A];
    assign irqEvent[`IRQ_OVF_B] = next_ctl[`OVF_FLAG_B] & ~tmrCtlFlags[`OVF_FLAG_B];
    assign irqEvent[`IRQ_DET_A] = next_ctl[`XIRQ_A_DETECT] & ~tmrCtlFlags[`XIRQ_A_DETECT];
    assign irqEvent[`IRQ_DET_B] = next_ctl[`XIRQ_B_DETECT] & ~tmrCtlFlags[`XIRQ_B_DETECT];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus <= 4'h0;
            irqEnable <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (wrPend && wrAddr == `ADDR_IRQ_CLEAR) begin
                irqStatus <= (irqStatus & ~hwdata[3:0]) | irqEvent;
            end else begin
                irqStatus <= irqStatus | irqEvent;
            end
            if (wrPend && wrAddr == `ADDR_IRQ_ENABLE) begin
                irqEnable <= hwdata[3:0];
            end
            irq <= |(irqStatus & irqEnable);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmrModeCfg <= `MODE_RESET;
            clkdivSel <= 8'h00;
        end else begin
            if (wrPend && wrAddr == {`IDX_MODE_CFG, 2'b00}) begin
                tmrModeCfg <= hwdata[7:0];
            end
            if (wrPend && wrAddr == {`IDX_CLKDIV_SEL, 2'b00}) begin
                clkdivSel <= hwdata[7:0] & 8'h18;
            end
        end
    end

    always_comb begin
        if (haddr[9:0] == {`IDX_CTL_FLAGS, 2'b00}) begin
            rdVal = {24'h0, tmrCtlFlags};
        end else if (haddr[9:0] == {`IDX_MODE_CFG, 2'b00}) begin
            rdVal = {24'h0, tmrModeCfg};
        end else if (haddr[9:0] == {`IDX_CNT_A_LOW, 2'b00}) begin
            rdVal = {24'h0, cntALow};
        end else if (haddr[9:0] == {`IDX_CNT_B_LOW, 2'b00}) begin
            rdVal = {24'h0, cntBLow};
        end else if (haddr[9:0] == {`IDX_CNT_A_HIGH, 2'b00}) begin
            rdVal = {24'h0, cntAHigh};
        end else if (haddr[9:0] == {`IDX_CNT_B_HIGH, 2'b00}) begin
            rdVal = {24'h0, cntBHigh};
        end else if (haddr[9:0] == {`IDX_CLKDIV_SEL, 2'b00}) begin
            rdVal = {24'h0, clkdivSel};
        end else if (haddr[9:0] == `ADDR_IRQ_STATUS) begin
            rdVal = {28'h0, irqStatus};
        end else if (haddr[9:0] == `ADDR_IRQ_ENABLE) begin
            rdVal = {28'h0, irqEnable};
        end else begin
            rdVal = 32'h0;
        end
    end

    // Zero wait states: read data is captured at the address phase, so it shows the state one edge earlier.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend <= 1'b0;
            wrAddr <= 10'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend <= hsel && htrans[1] && hready && hwrite && haddr[31:10] == 22'h0;
            wrAddr <= haddr[9:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= (haddr[31:10] == 22'h0) ? rdVal : 32'h0;
            end
        end
    end

    a_halt_keeps_b: assert property (@(posedge mclk) disable iff (!rst_b)
        !tmrCtlFlags[`RUN_CTL_B] && !wrPend |=> $stable({cntBHigh, cntBLow}))
        else $error("second timer moved while halted");
    a_halt_keeps_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !tmrCtlFlags[`RUN_CTL_A] && modeA != MODE_SPECIAL && !wrPend |=> $stable({cntAHigh, cntALow}))
        else $error("first timer moved while halted");
    a_edge_sets_det: assert property (@(posedge mclk) disable iff (!rst_b)
        tmrCtlFlags[`XIRQ_A_TYPE] && fallXA && !wrPend |=> tmrCtlFlags[`XIRQ_A_DETECT])
        else $error("edge did not set detect flag");
    a_edge_det_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        tmrCtlFlags[`XIRQ_A_TYPE] && tmrCtlFlags[`XIRQ_A_DETECT] && !svcStart.xirqA && !wrPend
        |=> tmrCtlFlags[`XIRQ_A_DETECT])
        else $error("edge detect flag dropped");
    a_level_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        rst_b && !tmrCtlFlags[`XIRQ_A_TYPE] && !wrPend |=> tmrCtlFlags[`XIRQ_A_DETECT] == !$past(pinLevel[2]))
        else $error("level detect flag wrong");
    a_gate_blocks_b: assert property (@(posedge mclk) disable iff (!rst_b)
        tmrModeCfg[`GATE_B] && !pinLevel[3] && !wrPend |=> $stable({cntBHigh, cntBLow}))
        else $error("gated timer counted");
    a_reload_low: assert property (@(posedge mclk) disable iff (!rst_b)
        modeB == MODE_RELOAD && stepB && cntBLow == `CNT_FULL && !wrPend |=> cntBLow == $past(cntBHigh))
        else $error("reload value not loaded");
    a_special_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        modeB == MODE_SPECIAL && !wrPend [*2] |-> $stable({cntBHigh, cntBLow}))
        else $error("second timer moved in mode 3");
    a_divider_range: assert property (@(posedge mclk) disable iff (!rst_b)
        rst_b && tickSlow |=> !tickSlow [*8] ##1 !tickSlow [*3] ##1 tickSlow)
        else $error("divider period wrong");
    a_ovf_sets: assert property (@(posedge mclk) disable iff (!rst_b)
        stepB && nextB[16] && modeA != MODE_SPECIAL |=> tmrCtlFlags[`OVF_FLAG_B])
        else $error("overflow flag not set");
endmodule : timer_pair_ctl

// File: pin_partner.sv
module pin_partner (
    input wire logic mclk,
    output timer_pair_pkg::pins_s pins,
    output timer_pair_pkg::svc_s svcStart
);
    timeunit 1ns;
    timeprecision 1ns;
    import timer_pair_pkg::*;
    // Interrupt pins idle high; every level is held long enough to pass the three-flop synchroniser.
    initial begin
        pins = '1;
        svcStart = '0;
    end
    task automatic pulse(int t);
        @(posedge mclk);
        pins[t] <= 1'b0;
        repeat (6) @(posedge mclk);
        pins[t] <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask : pulse
    task automatic set_pin(int i, logic v);
        @(posedge mclk);
        pins[i] <= v;
        repeat (8) @(posedge mclk);
    endtask : set_pin
    task automatic svc(int i);
        @(posedge mclk);
        svcStart[i] <= 1'b1;
        @(posedge mclk);
        svcStart[i] <= 1'b0;
        @(posedge mclk);
    endtask : svc
endmodule : pin_partner

// File: testbench.sv
`include "timer_pair_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_pair_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic rdPend = 1'b0;
    logic [31:0] hrdata;
    logic [7:0] ctlFlags;
    pins_s pins;
    svc_s svcStart;
    logic [31:0] expQ[$];
    int fails = 0;
    int compares = 0;

    timer_pair_ctl uut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pins(pins), .svcStart(svcStart), .ctlFlags(ctlFlags), .irq(irq));
    pin_partner far (.mclk(mclk), .pins(pins), .svcStart(svcStart));

    initial begin
        forever #10 mclk = ~mclk;
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] ra(logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction : ra

    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(logic [31:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(logic [31:0] a, logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Read data is taken at the edge that ends the data phase, before the slave moves on.
    always @(posedge mclk) begin
        if (rdPend && hreadyout === 1'b1) begin
            check(hrdata, expQ.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1) begin
            rdPend = hsel && htrans[1] && !hwrite;
        end
    end

    task automatic xirq_test(int t);
        logic [31:0] det;
        logic [31:0] typ;
        det = 32'h2 << (2 * t);
        typ = 32'h1 << (2 * t);
        wr(`ADDR_IRQ_ENABLE, 32'h4 << t);
        wr(ra(`IDX_CTL_FLAGS), typ);
        far.set_pin(2 + t, 1'b0);
        far.set_pin(2 + t, 1'b1);
        rd(ra(`IDX_CTL_FLAGS), typ | det);
        check({24'h0, ctlFlags}, typ | det);
        check({31'h0, irq}, 32'h1);
        far.svc(2 + t);
        rd(ra(`IDX_CTL_FLAGS), typ);
        rd(`ADDR_IRQ_STATUS, 32'h4 << t);
        wr(`ADDR_IRQ_CLEAR, 32'h4 << t);
        rd(`ADDR_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(ra(`IDX_CTL_FLAGS), 32'h0);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        far.set_pin(2 + t, 1'b0);
        rd(ra(`IDX_CTL_FLAGS), det);
        check({31'h0, irq}, 32'h0);
        far.set_pin(2 + t, 1'b1);
        rd(ra(`IDX_CTL_FLAGS), 32'h0);
        wr(`ADDR_IRQ_CLEAR, 32'hF);
        $display("test xirq %0d done", t);
    endtask : xirq_test

    task automatic tmr_test(int t);
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] ctl;
        logic [31:0] mode;
        logic [31:0] run;
        logic [31:0] ovf;
        logic [31:0] r;
        int s;
        int k;
        s = 4 * t;
        lo = ra(t ? `IDX_CNT_B_LOW : `IDX_CNT_A_LOW);
        hi = ra(t ? `IDX_CNT_B_HIGH : `IDX_CNT_A_HIGH);
        ctl = ra(`IDX_CTL_FLAGS);
        mode = ra(`IDX_MODE_CFG);
        run = 32'h10 << (2 * t);
        ovf = 32'h20 << (2 * t);
        k = 1 + $urandom % 5;
        r = $urandom % 256;
        wr(mode, 32'h1 << s);
        wr(lo, 32'h0);
        wr(hi, 32'h0);
        wr(ra(`IDX_CLKDIV_SEL), t ? 32'h0 : 32'h8);
        rd(ra(`IDX_CLKDIV_SEL), t ? 32'h0 : 32'h8);
        // The run window spans 120 edges, a whole number of ticks at either rate, so the divider phase drops out.
        wr(ctl, run);
        repeat (118) @(posedge mclk);
        wr(ctl, 32'h0);
        rd(lo, t ? 32'hA : 32'h1E);
        rd(hi, 32'h0);
        wr(mode, 32'h5 << s);
        wr(lo, 32'h0);
        wr(hi, 32'h0);
        wr(ctl, run);
        repeat (k) far.pulse(t);
        rd(lo, k);
        wr(ctl, 32'h0);
        repeat (2) far.pulse(t);
        rd(lo, k);
        rd(hi, 32'h0);
        wr(mode, 32'hD << s);
        wr(ctl, run);
        far.set_pin(2 + t, 1'b0);
        far.pulse(t);
        rd(lo, k);
        far.set_pin(2 + t, 1'b1);
        far.pulse(t);
        rd(lo, k + 1);
        wr(mode, 32'h5 << s);
        wr(lo, 32'hFF);
        wr(hi, 32'hFF);
        far.pulse(t);
        rd(ctl, run | ovf);
        rd(lo, 32'h0);
        rd(hi, 32'h0);
        far.svc(t);
        rd(ctl, run);
        wr(mode, 32'h4 << s);
        wr(lo, 32'h1F);
        wr(hi, 32'h0);
        far.pulse(t);
        rd(lo, 32'h0);
        rd(hi, 32'h1);
        wr(mode, 32'h6 << s);
        wr(hi, r);
        wr(lo, 32'hFF);
        far.pulse(t);
        rd(lo, r);
        rd(hi, r);
        wr(mode, 32'h7 << s);
        wr(lo, 32'hFF);
        wr(hi, 32'h0);
        far.pulse(t);
        rd(lo, t ? 32'hFF : 32'h0);
        rd(hi, 32'h0);
        $display("test timer %0d done", t);
    endtask : tmr_test

    initial begin
        void'($urandom(68061));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        check({31'h0, hreadyout}, 32'h1);
        rd(ra(`IDX_CTL_FLAGS), 32'h0);
        rd(ra(`IDX_MODE_CFG), 32'h0);
        rd(`ADDR_IRQ_ENABLE, 32'h0);
        wr(32'h3FC, 32'hFF);
        rd(32'h3FC, 32'h0);
        rd(32'h620, 32'h0);
        // Detect bits rise while the synchroniser still shows low pins after reset.
        wr(`ADDR_IRQ_CLEAR, 32'hF);
        $display("test registers done");
        for (int t = 0; t < 2; t++) xirq_test(t);
        for (int t = 0; t < 2; t++) tmr_test(t);
        wrap_up();
    end

    // About nine hundred cycles are needed; the limit leaves a wide margin.
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule : testbench
